// *** design/pdc_consts.vh ***
// constants for the pll divider configuration latch block
// assumes inclusion by bare name from files under design/ and sim/
`ifndef PDC_CONSTS_VH
`define PDC_CONSTS_VH

// configuration word layout, shared by shift register and latches
`define PDC_LOOP_W        9
`define PDC_OUT_W         2
`define PDC_DIAG_W        3
`define PDC_CFG_W         14
`define PDC_LOOP_LSB      0
`define PDC_LOOP_MSB      8
`define PDC_OUT_LSB       9
`define PDC_OUT_MSB       10
`define PDC_DIAG_LSB      11
`define PDC_DIAG_MSB      13

// idle level of the parallel load pin; its synchroniser and edge detector
// start here so leaving reset shows no false capture edge
`define PDC_PL_IDLE       1'b1

// axi4-lite register map
`define PDC_ADDR_W        4
`define PDC_OFS_CTRL      4'h0
`define PDC_OFS_STATUS    4'h4
`define PDC_OFS_SHIFT     4'h8
`define PDC_CTRL_PAR_EN   0
`define PDC_CTRL_SER_EN   1
`define PDC_CTRL_RST      2'h3
`define PDC_RESP_OKAY     2'h0
`define PDC_RESP_SLVERR   2'h2

// diagnostic select codes
`define PDC_DG_LOW        3'h0
`define PDC_DG_HIGH       3'h1
`define PDC_DG_SER_OUT    3'h2
`define PDC_DG_SER_CLK    3'h3
`define PDC_DG_PAR_LOAD   3'h4
`define PDC_DG_SER_LOAD   3'h5
`define PDC_DG_LOOP_LSB   3'h6
`define PDC_DG_OUT_LSB    3'h7

`endif

// *** design/pdc_sync.v ***
// two-flop synchroniser for a group of pin inputs
// assumes each bit is a slow level; no bus coherence is promised across bits
`timescale 1ns/1ps
module pdc_sync #(
  parameter         W     = 1,
  parameter [W-1:0] RST_V = {W{1'b0}}
) (
  input  wire         i_ref_clk,
  input  wire         i_rst,
  input  wire [W-1:0] i_d,
  output wire [W-1:0] o_q
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      // per-bit reset level, so a pin resting high does not fake an edge
      meta_ff <= RST_V;
      sync_ff <= RST_V;
    end else begin
      meta_ff <= i_d;
      sync_ff <= meta_ff;
    end
  end

  assign o_q = sync_ff;
endmodule

// *** design/pdc_top.v ***
// pll divider configuration latches with parallel and serial load paths
// assumes all pins are asynchronous to i_ref_clk and that the serial clock
// is much slower than i_ref_clk; software sees the block over axi4-lite
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "pdc_consts.vh"
module pdc_top (
  input  wire                   i_ref_clk,
  input  wire                   i_rst,
  input  wire                   i_par_load,
  input  wire [`PDC_LOOP_W-1:0] i_loop_divider,
  input  wire [`PDC_OUT_W-1:0]  i_output_divider,
  input  wire                   i_ser_clk,
  input  wire                   i_ser_data,
  input  wire                   i_ser_load,
  output reg  [`PDC_LOOP_W-1:0] o_loop_divider,
  output reg  [`PDC_OUT_W-1:0]  o_output_divider,
  output reg                    o_diag,
  input  wire [`PDC_ADDR_W-1:0] i_s_axi_awaddr,
  input  wire                   i_s_axi_awvalid,
  output reg                    o_s_axi_awready,
  input  wire [31:0]            i_s_axi_wdata,
  input  wire [3:0]             i_s_axi_wstrb,
  input  wire                   i_s_axi_wvalid,
  output reg                    o_s_axi_wready,
  output reg  [1:0]             o_s_axi_bresp,
  output reg                    o_s_axi_bvalid,
  input  wire                   i_s_axi_bready,
  input  wire [`PDC_ADDR_W-1:0] i_s_axi_araddr,
  input  wire                   i_s_axi_arvalid,
  output reg                    o_s_axi_arready,
  output reg  [31:0]            o_s_axi_rdata,
  output reg  [1:0]             o_s_axi_rresp,
  output reg                    o_s_axi_rvalid,
  input  wire                   i_s_axi_rready
);
  localparam SW = `PDC_LOOP_W + `PDC_OUT_W + 4;

  // pin synchronisers
  wire [SW-1:0] pin_sync;
  pdc_sync #(
    .W     (SW),
    .RST_V ({3'h0, `PDC_PL_IDLE, {(SW-4){1'b0}}})
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_d       ({i_ser_load, i_ser_data, i_ser_clk, i_par_load,
                 i_output_divider, i_loop_divider}),
    .o_q       (pin_sync)
  );

  wire [`PDC_LOOP_W-1:0] loop_s;
  wire [`PDC_OUT_W-1:0]  out_s;
  wire                   pl_s;
  wire                   sc_s;
  wire                   sd_s;
  wire                   sl_s;
  assign loop_s = pin_sync[`PDC_LOOP_W-1:0];
  assign out_s  = pin_sync[`PDC_LOOP_W+`PDC_OUT_W-1:`PDC_LOOP_W];
  assign pl_s   = pin_sync[SW-4];
  assign sc_s   = pin_sync[SW-3];
  assign sd_s   = pin_sync[SW-2];
  assign sl_s   = pin_sync[SW-1];

  reg                  sc_prev_ff;
  reg                  pl_prev_ff;
  reg [`PDC_CFG_W-1:0] shift_ff;
  reg [`PDC_CFG_W-1:0] cfg_ff;
  reg [1:0]            ctrl_ff;

  wire sc_rise;
  wire pl_rise;
  assign sc_rise = sc_s & ~sc_prev_ff;
  assign pl_rise = pl_s & ~pl_prev_ff;

  wire par_en;
  wire ser_en;
  assign par_en = ctrl_ff[`PDC_CTRL_PAR_EN];
  assign ser_en = ctrl_ff[`PDC_CTRL_SER_EN];

  // parallel word: bit 8 lands on the msb, bit 0 on the lsb
  wire [`PDC_CFG_W-1:0] par_word;
  assign par_word = {cfg_ff[`PDC_DIAG_MSB:`PDC_DIAG_LSB], out_s,
                     loop_s};

  // serial path; data is sampled with the same delay as the clock,
  // so a host that holds data around the clock edge is met
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      sc_prev_ff <= 1'b0;
      pl_prev_ff <= `PDC_PL_IDLE;
      shift_ff   <= {`PDC_CFG_W{1'b0}};
    end else begin
      sc_prev_ff <= sc_s;
      pl_prev_ff <= pl_s;
      if (sc_rise)
        shift_ff <= {shift_ff[`PDC_CFG_W-2:0], sd_s};
    end
  end

  // configuration latches; the serial path wins when both are open,
  // since the diagnostic field has no parallel source
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      cfg_ff <= {`PDC_CFG_W{1'b0}};
    end else if (ser_en && sl_s) begin
      cfg_ff <= shift_ff;
    end else if (par_en && (!pl_s || pl_rise)) begin
      cfg_ff <= par_word;
    end
  end

  // diagnostic mux
  reg nxt_diag;
  always @* begin
    case (cfg_ff[`PDC_DIAG_MSB:`PDC_DIAG_LSB])
      `PDC_DG_LOW:      nxt_diag = 1'b0;
      `PDC_DG_HIGH:     nxt_diag = 1'b1;
      `PDC_DG_SER_OUT:  nxt_diag = shift_ff[`PDC_CFG_W-1];
      `PDC_DG_SER_CLK:  nxt_diag = sc_s;
      `PDC_DG_PAR_LOAD: nxt_diag = pl_s;
      `PDC_DG_SER_LOAD: nxt_diag = sl_s;
      `PDC_DG_LOOP_LSB: nxt_diag = cfg_ff[`PDC_LOOP_LSB];
      `PDC_DG_OUT_LSB:  nxt_diag = cfg_ff[`PDC_OUT_LSB];
      default:          nxt_diag = 1'b0;
    endcase
  end

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_loop_divider   <= {`PDC_LOOP_W{1'b0}};
      o_output_divider <= {`PDC_OUT_W{1'b0}};
      o_diag           <= 1'b0;
    end else begin
      o_loop_divider   <= cfg_ff[`PDC_LOOP_MSB:`PDC_LOOP_LSB];
      o_output_divider <= cfg_ff[`PDC_OUT_MSB:`PDC_OUT_LSB];
      o_diag           <= nxt_diag;
    end
  end

  // axi4-lite write channel: address and data taken in either order
  reg [`PDC_ADDR_W-1:0] aw_addr_ff;
  reg                   aw_have_ff;
  reg [31:0]            w_data_ff;
  reg [3:0]             w_strb_ff;
  reg                   w_have_ff;

  wire [`PDC_ADDR_W-1:0] aw_word;
  wire [`PDC_ADDR_W-1:0] ar_word;
  assign aw_word = {aw_addr_ff[`PDC_ADDR_W-1:2], 2'b00};
  assign ar_word = {i_s_axi_araddr[`PDC_ADDR_W-1:2], 2'b00};

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready  <= 1'b1;
      o_s_axi_bvalid  <= 1'b0;
      o_s_axi_bresp   <= `PDC_RESP_OKAY;
      aw_addr_ff      <= {`PDC_ADDR_W{1'b0}};
      aw_have_ff      <= 1'b0;
      w_data_ff       <= 32'h0;
      w_strb_ff       <= 4'h0;
      w_have_ff       <= 1'b0;
      ctrl_ff         <= `PDC_CTRL_RST;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_addr_ff      <= i_s_axi_awaddr;
        aw_have_ff      <= 1'b1;
        o_s_axi_awready <= 1'b0;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_data_ff      <= i_s_axi_wdata;
        w_strb_ff      <= i_s_axi_wstrb;
        w_have_ff      <= 1'b1;
        o_s_axi_wready <= 1'b0;
      end
      if (aw_have_ff && w_have_ff && !o_s_axi_bvalid) begin
        aw_have_ff     <= 1'b0;
        w_have_ff      <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        if (aw_word == `PDC_OFS_CTRL) begin
          o_s_axi_bresp <= `PDC_RESP_OKAY;
          if (w_strb_ff[0])
            ctrl_ff <= w_data_ff[`PDC_CTRL_SER_EN:`PDC_CTRL_PAR_EN];
        end else if (aw_word == `PDC_OFS_STATUS ||
                     aw_word == `PDC_OFS_SHIFT) begin
          // read-only registers ignore the data but answer okay
          o_s_axi_bresp <= `PDC_RESP_OKAY;
        end else begin
          o_s_axi_bresp <= `PDC_RESP_SLVERR;
        end
      end
      if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid  <= 1'b0;
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready  <= 1'b1;
      end
    end
  end

  // axi4-lite read channel
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= 32'h0;
      o_s_axi_rresp   <= `PDC_RESP_OKAY;
    end else begin
      if (i_s_axi_arvalid && o_s_axi_arready) begin
        o_s_axi_arready <= 1'b0;
        o_s_axi_rvalid  <= 1'b1;
        o_s_axi_rresp   <= `PDC_RESP_OKAY;
        if (ar_word == `PDC_OFS_CTRL)
          o_s_axi_rdata <= {30'h0, ctrl_ff};
        else if (ar_word == `PDC_OFS_STATUS)
          o_s_axi_rdata <= {{(32-`PDC_CFG_W){1'b0}}, cfg_ff};
        else if (ar_word == `PDC_OFS_SHIFT)
          o_s_axi_rdata <= {{(32-`PDC_CFG_W){1'b0}}, shift_ff};
        else begin
          o_s_axi_rdata <= 32'h0;
          o_s_axi_rresp <= `PDC_RESP_SLVERR;
        end
      end
      if (o_s_axi_rvalid && i_s_axi_rready) begin
        o_s_axi_rvalid  <= 1'b0;
        o_s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// *** sim/pdc_host.sv ***
// host model driving the parallel and serial configuration pins
// assumes each task is entered just after a rising edge of i_clk
`timescale 1ns/1ps
module pdc_host (
  input  wire        i_clk,
  output logic       o_pl,
  output logic [8:0] o_m,
  output logic [1:0] o_n,
  output logic       o_sc,
  output logic       o_sd,
  output logic       o_sl
);
  initial begin
    o_pl = 1;
    {o_n, o_m} = 0;
    {o_sc, o_sd, o_sl} = 0;
  end
  task wt(input int c);
    repeat (c) @(posedge i_clk);
  endtask
  // pins change after the hold so a late capture would show up
  task par(input [10:0] v);
    {o_n, o_m} <= v;
    o_pl <= 0;
    wt(10);
    o_pl <= 1;
    wt(10);
    {o_n, o_m} <= ~v;
    wt(1);
  endtask
  // link clock runs only inside a frame, 160 ns period, msb first
  task ser(input [13:0] w);
    for (int i = 13; i >= 0; i--) begin
      o_sd <= w[i];
      wt(20);
      o_sc <= 1;
      wt(20);
      o_sc <= 0;
    end
    o_sd <= ~w[0];
    o_sl <= 1;
    wt(12);
    o_sl <= 0;
    wt(12);
  endtask
endmodule

// *** sim/pdc_chk_sva.sv ***
// assertions for the configuration latch block
// assumes host pins stay steady for several clocks around every strobe
`timescale 1ns/1ps
module pdc_chk (
  input wire        i_ref_clk,
  input wire        i_rst,
  input wire        i_par_load,
  input wire [8:0]  i_loop_divider,
  input wire        i_ser_clk,
  input wire        i_ser_data,
  input wire        i_ser_load,
  input wire [8:0]  o_loop_divider,
  input wire [1:0]  o_output_divider,
  input wire [3:0]  i_s_axi_awaddr,
  input wire        i_s_axi_awvalid,
  input wire        o_s_axi_awready,
  input wire [31:0] i_s_axi_wdata,
  input wire        i_s_axi_wvalid,
  input wire        o_s_axi_wready,
  input wire        o_s_axi_bvalid,
  input wire        i_s_axi_bready,
  input wire        i_s_axi_arvalid,
  input wire        o_s_axi_arready,
  input wire        o_s_axi_rvalid,
  input wire        i_s_axi_rready
);
  reg [13:0] sh_ff;
  reg        sc_ff;
  reg [3:0]  ca_ff;
  reg [1:0]  cd_ff;
  reg [1:0]  en_ff;
  reg        bv_ff;
  // shadow of the path enables, one cycle behind the block's own copy;
  // the properties below only need it steady across their windows
  always @(posedge i_ref_clk) begin
    bv_ff <= o_s_axi_bvalid;
    if (i_s_axi_awvalid && o_s_axi_awready) ca_ff <= i_s_axi_awaddr;
    if (i_s_axi_wvalid && o_s_axi_wready) cd_ff <= i_s_axi_wdata[1:0];
    if (i_rst) en_ff <= 2'h3;
    else if (o_s_axi_bvalid && !bv_ff && ca_ff[3:2] == 2'h0) en_ff <= cd_ff;
  end
  // own copy of the shift register, taken straight from the pins
  always @(posedge i_ref_clk) begin
    sc_ff <= i_ser_clk;
    if (i_ser_clk && !sc_ff) sh_ff <= {sh_ff[12:0], i_ser_data};
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  chk_b_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
    o_s_axi_bvalid) else $error("bvalid dropped early");
  chk_r_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
    o_s_axi_rvalid) else $error("rvalid dropped early");
  chk_ar_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=>
    o_s_axi_rvalid) else $error("read not answered");
  chk_aw_block: assert property (o_s_axi_bvalid |-> !o_s_axi_awready)
    else $error("write taken with response pending");
  chk_ar_block: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read taken with response pending");
  chk_par_hold: assert property (
    (i_par_load && !i_ser_load)[*8] |-> $stable(o_loop_divider) &&
    $stable(o_output_divider)) else $error("latches moved while held");
  chk_par_follow: assert property (
    (en_ff[0] && !i_par_load && !i_ser_load && $stable(i_loop_divider))[*8]
    |-> o_loop_divider == i_loop_divider) else $error("pins not followed");
  chk_ser_follow: assert property (
    (en_ff[1] && i_ser_load && !i_ser_clk)[*8] |->
    {o_output_divider, o_loop_divider} == sh_ff[10:0])
    else $error("serial word not followed");
  chk_par_refuse: assert property (
    (!en_ff[0] && !i_ser_load)[*8] |-> $stable(o_loop_divider) &&
    $stable(o_output_divider)) else $error("disabled latches moved");
endmodule
bind pdc_top pdc_chk u_chk (
  .i_ref_clk        (i_ref_clk),
  .i_rst            (i_rst),
  .i_par_load       (i_par_load),
  .i_loop_divider   (i_loop_divider),
  .i_ser_clk        (i_ser_clk),
  .i_ser_data       (i_ser_data),
  .i_ser_load       (i_ser_load),
  .o_loop_divider   (o_loop_divider),
  .o_output_divider (o_output_divider),
  .i_s_axi_awaddr   (i_s_axi_awaddr),
  .i_s_axi_awvalid  (i_s_axi_awvalid),
  .o_s_axi_awready  (o_s_axi_awready),
  .i_s_axi_wdata    (i_s_axi_wdata),
  .i_s_axi_wvalid   (i_s_axi_wvalid),
  .o_s_axi_wready   (o_s_axi_wready),
  .o_s_axi_bvalid   (o_s_axi_bvalid),
  .i_s_axi_bready   (i_s_axi_bready),
  .i_s_axi_arvalid  (i_s_axi_arvalid),
  .o_s_axi_arready  (o_s_axi_arready),
  .o_s_axi_rvalid   (o_s_axi_rvalid),
  .i_s_axi_rready   (i_s_axi_rready)
);

// *** sim/tb_top.sv ***
// bench: host model on the pins, axi4-lite tasks for software access
// assumes the checker is bound in from its own file
`timescale 1ns/1ps
`include "pdc_consts.vh"
module tb_top;
  logic        clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic [3:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0;
  logic [10:0] pv [3] = '{11'h001, 11'h100, 11'h6aa};
  logic [2:0]  dc [8] = '{`PDC_DG_LOW, `PDC_DG_HIGH, `PDC_DG_SER_OUT,
                          `PDC_DG_SER_CLK, `PDC_DG_PAR_LOAD,
                          `PDC_DG_SER_LOAD, `PDC_DG_LOOP_LSB,
                          `PDC_DG_OUT_LSB};
  logic [13:0] w;
  logic        e;
  wire         pl, sc, sd, sl, dg, awr, wrd, bv, arr, rv;
  wire  [8:0]  m, ld;
  wire  [1:0]  n, od, br, rr;
  wire  [31:0] rdat;
  int          err_count = 0, compares = 0;
  initial forever #2 clk = ~clk;
  pdc_host host (.i_clk(clk), .o_pl(pl), .o_m(m), .o_n(n), .o_sc(sc),
    .o_sd(sd), .o_sl(sl));
  pdc_top uut (.i_ref_clk(clk), .i_rst(rst), .i_par_load(pl),
    .i_loop_divider(m), .i_output_divider(n), .i_ser_clk(sc),
    .i_ser_data(sd), .i_ser_load(sl), .o_loop_divider(ld),
    .o_output_divider(od), .o_diag(dg), .i_s_axi_awaddr(awa),
    .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd),
    .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wv), .o_s_axi_wready(wrd),
    .o_s_axi_bresp(br), .o_s_axi_bvalid(bv), .i_s_axi_bready(bre),
    .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
    .o_s_axi_rdata(rdat), .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv),
    .i_s_axi_rready(rre));
  task chk(input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h exp %h", $time, s, e);
    end
  endtask
  task tally_and_finish;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ready is raised only after valid shows, so the slave must hold it
  task bus(input bit wr, input [3:0] a, input [31:0] d, input [1:0] r);
    int k;
    awa <= a;
    ara <= a;
    wd <= d;
    awv <= wr;
    wv <= wr;
    arv <= !wr;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (awr && awv) awv <= 0;
      if (wrd && wv) wv <= 0;
      if (arr && arv) arv <= 0;
      if (bv && bre || rv && rre) break;
      bre <= bv;
      rre <= rv;
    end
    bre <= 0;
    rre <= 0;
    chk(k == 50, 0);
    if (k == 50) tally_and_finish;
    chk(wr ? br : rr, r);
    if (!wr) chk(rdat, d);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    chk(ld, 9'h0);
    bus(0, `PDC_OFS_CTRL, 32'h3, `PDC_RESP_OKAY);
    bus(1, `PDC_OFS_CTRL, 32'h3, `PDC_RESP_OKAY);
    bus(1, 4'hc, 32'h0, `PDC_RESP_SLVERR);
    bus(0, 4'hc, 32'h0, `PDC_RESP_SLVERR);
    foreach (pv[i]) begin
      host.par(pv[i]);
      chk(ld, pv[i][8:0]);
      chk(od, pv[i][10:9]);
    end
    // each load path must ignore its pins while its enable is clear
    bus(1, `PDC_OFS_CTRL, 32'h2, `PDC_RESP_OKAY);
    host.par(11'h155);
    chk(ld, pv[2][8:0]);
    chk(od, pv[2][10:9]);
    bus(1, `PDC_OFS_CTRL, 32'h1, `PDC_RESP_OKAY);
    host.ser(14'h3d5c);
    bus(0, `PDC_OFS_SHIFT, 32'h3d5c, `PDC_RESP_OKAY);
    bus(0, `PDC_OFS_STATUS, {18'h0, 3'h0, pv[2]}, `PDC_RESP_OKAY);
    bus(1, `PDC_OFS_STATUS, 32'h0, `PDC_RESP_OKAY);
    bus(0, `PDC_OFS_STATUS, {18'h0, 3'h0, pv[2]}, `PDC_RESP_OKAY);
    bus(1, `PDC_OFS_CTRL, 32'h3, `PDC_RESP_OKAY);
    foreach (dc[k]) begin
      w = {dc[k], 11'h2ab + 11'(k)};
      host.ser(w);
      bus(0, `PDC_OFS_STATUS, {18'h0, w}, `PDC_RESP_OKAY);
      chk({od, ld}, w[10:0]);
      // pins rest with parallel load high, serial clock and load low
      case (dc[k])
        `PDC_DG_HIGH, `PDC_DG_PAR_LOAD: e = 1'b1;
        `PDC_DG_SER_OUT:  e = w[13];
        `PDC_DG_LOOP_LSB: e = w[0];
        `PDC_DG_OUT_LSB:  e = w[9];
        default:          e = 1'b0;
      endcase
      chk(dg, e);
    end
    tally_and_finish;
  end
endmodule
